// [rtl/cprc_ctrl.sv]
// Charge pump and regulator control block with APB register access
//
// Behaviour
// - Pump clock is fsys/16/(divider+1)
// - Module disable powers everything off
// - Pump enable selects doubled or passed supply
// - Off-state select: 0 pulldown, 1 floating
// - Quick-start bit shorts filter when zero
// - Output-state bits 7..1 read zero
module cprc_ctrl #(
   parameter int unsigned QS_MIN_CYC = cprc_pkg::CPRC_QS_MIN_CYC
) (
   // Clock and asynchronous active-low reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Register bus, slave side
   input wire cprc_pkg::cprc_apb_req_t apb_req_i,
   output cprc_pkg::cprc_apb_rsp_t apb_rsp_o,
   // Analog section controls and pump clock pulse
   output cprc_pkg::cprc_power_t power_o,
   output logic pump_clk_tick_o
);
   // Register map, field layout and carrier types
   import cprc_pkg::*;

   // Low-time counter is wide enough to hold the mark itself
   localparam int unsigned QS_W = $clog2(QS_MIN_CYC + 1);

   // Refuse a zero quick-start time, a mark the counter cannot reach, and a layout
   // whose divider field would spill out of the 8-bit control register
   initial begin
      if (QS_MIN_CYC < 1) begin
         $error("cprc_ctrl: QS_MIN_CYC must be at least 1");
      end
      if (QS_MIN_CYC > 32'h7fffffff) begin
         $error("cprc_ctrl: QS_MIN_CYC too large for the low-time counter");
      end
      if (CPRC_DIV_LSB + CPRC_DIV_W > 8) begin
         $error("cprc_ctrl: divider field does not fit the control register");
      end
   end

   // Software-visible storage
   logic [7:0] control; // Control register
   logic [7:0] out_state; // Output-state register

   // Quick-start measurement and read path
   logic [QS_W-1:0] qs_cnt; // Quick-start low-time counter
   logic qs_settled; // Quick-start low time reached
   logic [CPRC_DATA_W-1:0] rdata; // Registered read data

   // Field views of the control and output-state registers
   logic module_enable; // Module enable field
   logic pump_enable; // Pump enable field
   logic quick_start; // Quick-start field
   logic [CPRC_DIV_W-1:0] pump_clock_divider; // Divider field
   logic off_output_state_select; // Output state while off

   // Bus decode
   logic setup; // APB setup phase
   logic access; // APB access phase
   logic aligned; // Word-aligned address
   logic [9:0] idx; // Register index from address
   logic hit_control; // Control register addressed
   logic hit_out_state; // Output-state register addressed
   logic hit_status; // Status register addressed
   logic mapped; // Any register addressed
   logic wr_low; // Write to low byte accepted
   logic div_rewrite; // Divider field written

   // Read-only status view
   logic [7:0] status; // Status view

   // Named views of the fields; the rest of the block reads only these, except the control read-back, which reads control directly
   assign module_enable = control[CPRC_MODULE_ENABLE_BIT];
   assign pump_enable = control[CPRC_PUMP_ENABLE_BIT];
   assign quick_start = control[CPRC_QUICK_START_BIT];
   assign pump_clock_divider = control[CPRC_DIV_LSB +: CPRC_DIV_W];
   assign off_output_state_select = out_state[CPRC_OFF_STATE_BIT];

   // Address decode: the index is the word address, and a byte address that is not
   // word aligned matches nothing, so it is refused rather than aliased onto a register
   assign setup = apb_req_i.psel && !apb_req_i.penable;
   assign access = apb_req_i.psel && apb_req_i.penable;
   assign aligned = (apb_req_i.paddr[1:0] == 2'b00);
   assign idx = apb_req_i.paddr[11:2];
   assign hit_control = aligned && (idx == CPRC_IDX_CONTROL);
   assign hit_out_state = aligned && (idx == CPRC_IDX_OUT_STATE);
   assign hit_status = aligned && (idx == CPRC_IDX_STATUS);
   assign mapped = hit_control || hit_out_state || hit_status;
   assign wr_low = access && apb_req_i.pwrite && apb_req_i.pstrb[0];
   assign div_rewrite = wr_low && hit_control;

   // Slave always answers in the first access cycle; unmapped gets an error.
   // No wait states are needed because read data is staged in the setup cycle
   // and stands unchanged through the access cycle.
   assign apb_rsp_o.pready = 1'b1;
   assign apb_rsp_o.pslverr = access && !mapped;
   assign apb_rsp_o.prdata = rdata;

   // Control register: fully software read/write. A write lands only at the access
   // edge and only when byte lane 0 is enabled; the upper lanes carry nothing here.
   // The reset value keeps the whole module powered down until software acts.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         control <= CPRC_CONTROL_RST;
      end else if (wr_low && hit_control) begin
         control <= apb_req_i.pwdata[7:0];
      end
   end

   // Output-state register: only bit 0 is kept. Bits 7..1 are never stored,
   // so they can only ever read back as zero, whatever software writes there.
   // The select resets to the pulled-down choice.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_state <= CPRC_OUT_STATE_RST;
      end else if (wr_low && hit_out_state) begin
         out_state <= {7'h00, apb_req_i.pwdata[CPRC_OFF_STATE_BIT]};
      end
   end

   // Measures how long the filter short is held while enabled. The count stops at
   // the mark rather than wrapping, so a long hold can never look short again;
   // releasing quick start or disabling the module starts the measure over.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         qs_cnt <= '0;
      end else if (!module_enable || quick_start) begin
         qs_cnt <= '0;
      end else if (qs_cnt != QS_W'(QS_MIN_CYC)) begin
         // One more cycle of the short
         qs_cnt <= qs_cnt + QS_W'(1);
      end
   end

   // Settled flag: set once the short was held long enough, lost on disable.
   // Disable takes priority; releasing quick start afterwards keeps the flag,
   // since the band gap has already had its fast start.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         qs_settled <= 1'b0;
      end else if (!module_enable) begin
         qs_settled <= 1'b0;
      end else if (qs_cnt == QS_W'(QS_MIN_CYC)) begin
         // Mark reached
         qs_settled <= 1'b1;
      end
   end

   // Status view of the block's own state; software may poll it after enabling
   // the module to learn when the quick-start hold has lasted long enough.
   // Writes to this view are ignored.
   always_comb begin
      // Unused bits read zero
      status = 8'h00;
      status[CPRC_STAT_SETTLED_BIT] = qs_settled;
      status[CPRC_STAT_REG_ON_BIT] = module_enable;
      status[CPRC_STAT_PUMP_ON_BIT] = module_enable && pump_enable;
   end

   // Read data captured in the setup phase, zero for unmapped addresses.
   // Capturing early keeps prdata steady for the whole access cycle, even when
   // the register underneath changes at the access edge.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata <= '0;
      end else if (setup) begin
         // Pick the addressed register
         if (hit_control) begin
            rdata <= {24'h000000, control};
         end else if (hit_out_state) begin
            rdata <= {24'h000000, 7'h00, off_output_state_select};
         end else if (hit_status) begin
            rdata <= {24'h000000, status};
         end else begin
            rdata <= '0;
         end
      end
   end

   // Power controls, registered so the analog section never sees a glitch from the
   // bus decode; they follow a control write one cycle after it lands. While the
   // module is off the pump enable is ignored and the output state select applies.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // Everything powered down during reset
         power_o.regulator_on <= 1'b0;
         power_o.pump_on <= 1'b0;
         power_o.amp_converter_power <= 1'b0;
         power_o.bandgap_filter_short <= 1'b0;
         power_o.output_pulldown <= 1'b0;
         power_o.output_floating <= 1'b0;
      end else begin
         // Module and pump power
         power_o.regulator_on <= module_enable;
         power_o.pump_on <= module_enable && pump_enable;
         power_o.amp_converter_power <= module_enable;
         // Band-gap filter short while quick start is low
         power_o.bandgap_filter_short <= !quick_start;
         // Regulated output while the regulator is off
         power_o.output_pulldown <= !module_enable && !off_output_state_select;
         power_o.output_floating <= !module_enable && off_output_state_select;
      end
   end

   // Pump clock runs only while the pump is on. Any control write restarts it, so
   // a new divider takes effect from a clean phase instead of mid-count; the first
   // pulse then follows a full period of the new setting.
   cprc_pump_clock_div #(
      .PRESCALE(CPRC_PRESCALE),
      .DIV_W(CPRC_DIV_W)
   ) u_div (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .run_i(module_enable && pump_enable),
      .restart_i(div_rewrite),
      .div_i(pump_clock_divider),
      .tick_o(pump_clk_tick_o)
   );

endmodule : cprc_ctrl

// [rtl/cprc_pump_clock_div.sv]
// Pump clock divider: fixed prescale then programmable divide-by-(N+1)
module cprc_pump_clock_div #(
   parameter int unsigned PRESCALE = 16,
   parameter int unsigned DIV_W = 5
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic run_i,
   input wire logic restart_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic tick_o
);

   localparam int unsigned PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);

   // Refuse settings the counters cannot serve
   initial begin
      if (PRESCALE < 1 || DIV_W < 1) begin
         $error("cprc_pump_clock_div: bad PRESCALE or DIV_W");
      end
   end

   logic [PRE_W-1:0] pre_cnt; // Prescale phase
   logic [DIV_W-1:0] div_cnt; // Divider phase
   logic pre_wrap; // Prescaler finishes a period

   assign pre_wrap = (pre_cnt == PRE_LAST);

   // Prescaler; held clear while stopped or restarted
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_cnt <= '0;
      end else if (!run_i || restart_i) begin
         pre_cnt <= '0;
      end else if (pre_wrap) begin
         pre_cnt <= '0;
      end else begin
         pre_cnt <= pre_cnt + PRE_W'(1);
      end
   end

   // Divider counts prescaled periods up to the field value
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt <= '0;
      end else if (!run_i || restart_i) begin
         div_cnt <= '0;
      end else if (pre_wrap) begin
         if (div_cnt >= div_i) begin
            div_cnt <= '0;
         end else begin
            div_cnt <= div_cnt + DIV_W'(1);
         end
      end
   end

   // One-cycle pump clock pulse at fsys/PRESCALE/(div+1)
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= run_i && !restart_i && pre_wrap && (div_cnt >= div_i);
      end
   end

endmodule : cprc_pump_clock_div

// [shared/cprc_pkg.sv]
// Package with register map, field layout and timing for the pump/regulator control
package cprc_pkg;

   // Bus widths
   localparam int unsigned CPRC_ADDR_W = 12;
   localparam int unsigned CPRC_DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [9:0] CPRC_IDX_CONTROL = 10'h01f;
   localparam logic [9:0] CPRC_IDX_OUT_STATE = 10'h020;
   localparam logic [9:0] CPRC_IDX_STATUS = 10'h021;

   // Control register field positions
   localparam int unsigned CPRC_MODULE_ENABLE_BIT = 0;
   localparam int unsigned CPRC_PUMP_ENABLE_BIT = 1;
   localparam int unsigned CPRC_QUICK_START_BIT = 2;
   localparam int unsigned CPRC_DIV_LSB = 3;
   localparam int unsigned CPRC_DIV_W = 5;

   // Output-state register field position
   localparam int unsigned CPRC_OFF_STATE_BIT = 0;

   // Status register field positions
   localparam int unsigned CPRC_STAT_SETTLED_BIT = 0;
   localparam int unsigned CPRC_STAT_REG_ON_BIT = 1;
   localparam int unsigned CPRC_STAT_PUMP_ON_BIT = 2;

   // Reset values
   localparam logic [7:0] CPRC_CONTROL_RST = 8'h00;
   localparam logic [7:0] CPRC_OUT_STATE_RST = 8'h00;

   // Fixed prescaler ahead of the programmable divider
   localparam int unsigned CPRC_PRESCALE = 16;

   // Timing: clock rate and least quick-start low time
   localparam int unsigned CPRC_CLK_MHZ = 250;
   localparam int unsigned CPRC_QS_MIN_US = 2000;
   localparam int unsigned CPRC_QS_MIN_CYC = CPRC_QS_MIN_US * CPRC_CLK_MHZ;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [CPRC_ADDR_W-1:0] paddr;
      logic [CPRC_DATA_W-1:0] pwdata;
      logic [3:0] pstrb;
   } cprc_apb_req_t;

   // APB answer to the master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [CPRC_DATA_W-1:0] prdata;
   } cprc_apb_rsp_t;

   // Power controls to the analog section
   typedef struct packed {
      logic regulator_on;
      logic pump_on;
      logic amp_converter_power;
      logic bandgap_filter_short;
      logic output_pulldown;
      logic output_floating;
   } cprc_power_t;

endpackage : cprc_pkg

// [tb/cprc_ctrl_props.sv]
// Checker for power controls, pump ticks and register reads of the control block
module cprc_ctrl_props
   import cprc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire cprc_pkg::cprc_apb_req_t apb_req_i,
   input wire cprc_pkg::cprc_apb_rsp_t apb_rsp_o,
   input wire cprc_pkg::cprc_power_t power_o,
   input wire logic pump_clk_tick_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Completed write to the control register with its byte enabled
   sequence ctl_wr;
      apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && apb_req_i.pstrb[0]
         && apb_req_i.paddr == 12'h07c;
   endsequence
   // Completed read of the output-state register
   sequence sel_rd;
      apb_req_i.psel && apb_req_i.penable && !apb_req_i.pwrite && apb_req_i.paddr == 12'h080;
   endsequence
   module_enable_a: assert property (ctl_wr |-> ##2
      power_o.regulator_on == $past(apb_req_i.pwdata[0], 2))
      else $error("regulator power does not follow module enable");
   pump_follow_a: assert property (ctl_wr |-> ##2
      power_o.pump_on == ($past(apb_req_i.pwdata[0], 2) && $past(apb_req_i.pwdata[1], 2)))
      else $error("pump power does not follow its enables");
   quick_short_a: assert property (ctl_wr |-> ##2
      power_o.bandgap_filter_short != $past(apb_req_i.pwdata[2], 2))
      else $error("filter short does not follow quick start");
   amp_power_a: assert property (power_o.amp_converter_power == power_o.regulator_on)
      else $error("amplifier power differs from regulator power");
   off_state_a: assert property (power_o.regulator_on |->
      !power_o.output_pulldown && !power_o.output_floating)
      else $error("output state applied while regulator runs");
   tick_gap_a: assert property (pump_clk_tick_o |=> !pump_clk_tick_o [*8])
      else $error("pump ticks closer than the prescale allows");
   tick_pump_a: assert property (pump_clk_tick_o |-> power_o.pump_on)
      else $error("pump tick while pump is off");
   unused_zero_a: assert property (sel_rd |-> apb_rsp_o.prdata[31:1] == 31'h0)
      else $error("unused output-state bits read nonzero");
endmodule : cprc_ctrl_props

bind cprc_ctrl cprc_ctrl_props i_cprc_ctrl_props (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .power_o(power_o),
   .pump_clk_tick_o(pump_clk_tick_o));

// [tb/cprc_ctrl_tb.sv]
// Self-checking bench for the pump and regulator control block
module cprc_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cprc_pkg::*;
   logic sys_clk_i = 1'b0; // Bench clock
   logic rst_b_i = 1'b0; // Reset, held low at start
   cprc_apb_req_t req = '0; // Bus request
   cprc_apb_rsp_t rsp; // Bus answer
   cprc_power_t pwr; // Power controls
   logic tick; // Pump clock pulse
   int num_errors = 0;
   int checks = 0;
   logic [31:0] seed = 32'h36f8ed12; // Random state
   logic [31:0] rd; // Last read data
   logic err; // Last error flag
   logic [7:0] ctl; // Control value written
   logic [7:0] sel; // Output-state value written
   int n; // Cycle counter
   // Clock toggles every half period
   always #2 sys_clk_i = ~sys_clk_i;
   // Quick-start count is shortened for the run
   localparam int QS_CYC = 20;
   cprc_ctrl #(.QS_MIN_CYC(QS_CYC)) i_cprc_ctrl (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .apb_req_i(req), .apb_rsp_o(rsp), .power_o(pwr), .pump_clk_tick_o(tick));
   // Next random value
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Expected power controls from control and output-state bits
   function automatic cprc_power_t exp_pwr(input logic [7:0] c, input logic s);
      return {c[0], c[0] & c[1], c[0], ~c[2], ~c[0] & ~s, ~c[0] & s};
   endfunction : exp_pwr
   // Expected status word from settled, regulator and pump state
   function automatic logic [31:0] exp_stat(input logic s, input logic r, input logic p);
      logic [31:0] v;
      v = '0;
      v[CPRC_STAT_SETTLED_BIT] = s;
      v[CPRC_STAT_REG_ON_BIT] = r;
      v[CPRC_STAT_PUMP_ON_BIT] = p;
      return v;
   endfunction : exp_stat
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One bus transfer, entered just after a rising edge, one idle cycle after
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d, 4'hf};
      @(posedge sys_clk_i);
      req.penable <= 1'b1;
      do @(posedge sys_clk_i); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb
   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   // Watchdog cuts a hang short
   initial begin
      #200us;
      num_errors++;
      close_out();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(posedge sys_clk_i);
      apb(1'b0, 12'h07c, '0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h080, '0);
      chk(rd, 32'h0);
      // Corner settings first, then random ones
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         ctl = (i == 0) ? 8'h03 : (i == 1) ? 8'hfe : seed[7:0];
         sel = seed[15:8];
         apb(1'b1, 12'h080, {seed[31:8], sel});
         apb(1'b1, 12'h07c, {seed[31:8], ctl});
         #1;
         chk(32'(pwr), 32'(exp_pwr(ctl, sel[0])));
         @(posedge sys_clk_i);
         apb(1'b0, 12'h07c, '0);
         chk(rd, {24'h0, ctl});
         apb(1'b0, 12'h080, '0);
         chk(rd, {31'h0, sel[0]});
      end
      apb(1'b0, 12'h010, '0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // Quick start held low: status read early, mid-way and after the mark
      apb(1'b1, 12'h07c, 32'h01);
      apb(1'b0, 12'h084, '0);
      chk(rd, exp_stat(1'b0, 1'b1, 1'b0));
      repeat (QS_CYC - 10) @(posedge sys_clk_i);
      apb(1'b0, 12'h084, '0);
      chk(rd, exp_stat(1'b0, 1'b1, 1'b0));
      repeat (10) @(posedge sys_clk_i);
      apb(1'b0, 12'h084, '0);
      chk(rd, exp_stat(1'b1, 1'b1, 1'b0));
      // Releasing quick start keeps the flag; disabling the module clears it
      apb(1'b1, 12'h07c, 32'h07);
      apb(1'b0, 12'h084, '0);
      chk(rd, exp_stat(1'b1, 1'b1, 1'b1));
      apb(1'b1, 12'h07c, 32'h00);
      apb(1'b0, 12'h084, '0);
      chk(rd, exp_stat(1'b0, 1'b0, 1'b0));
      // A misaligned write is refused and leaves the control register alone
      apb(1'b1, 12'h07d, 32'hff);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h07c, '0);
      chk(rd, 32'h0);
      // Pump clock period: smallest, largest, the advised settings, then random
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         ctl = {(i == 0) ? 5'h00 : (i == 1) ? 5'h1f : seed[4:0], 3'b111};
         ctl[7:3] = (i == 2) ? 5'h0b : (i == 3) ? 5'h05 : ctl[7:3];
         apb(1'b1, 12'h07c, {24'h0, ctl});
         while (tick !== 1'b1) @(negedge sys_clk_i);
         n = 0;
         do begin
            @(negedge sys_clk_i);
            n++;
         end while (tick !== 1'b1);
         chk(32'(n), 32'(16 * (int'(ctl[7:3]) + 1)));
         @(posedge sys_clk_i);
      end
      close_out();
   end
endmodule : cprc_ctrl_tb
